// file: logic/ahp_pkg.sv
package ahp_pkg;
  // Drive clock
  localparam int CLK_PERIOD_NS = 40;
  // Longest wait-state stretch, rounded down to whole cycles
  localparam int IORDY_MAX_NS = 1250;
  localparam int IORDY_MAX_CYC = IORDY_MAX_NS / CLK_PERIOD_NS;
  // Tightest strobe-to-request change (mode 2), at least one cycle
  localparam int DMARQ_MAX_NS = 35;
  localparam int DMARQ_MAX_CYC =
    (DMARQ_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 : DMARQ_MAX_NS / CLK_PERIOD_NS;
  // Bit positions in the synchronised pin vector
  localparam int PIN_DD = 0;
  localparam int PIN_DA = 16;
  localparam int PIN_CS0 = 19;
  localparam int PIN_CS1 = 20;
  localparam int PIN_RD = 21;
  localparam int PIN_WR = 22;
  localparam int PIN_ACK = 23;
  localparam int PIN_DIAG = 24;
  localparam int PIN_SLAVE = 25;
  localparam int PIN_W = 26;
  // Control block sits at 3F6/3F7: upper address bits both set
  localparam logic [1:0] CTL_ADDR_HI = 2'h3;
  localparam logic [2:0] DATA_REG_ADDR = 3'h0;
  localparam logic [15:0] BYTE_MASK = 16'h00ff;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  typedef enum {RD_IDLE, RD_WAIT, RD_HOLD} ahp_rd_state_t;
endpackage

// file: logic/ahp_host_port.sv
`timescale 1ns/1ps
// Notes on behaviour
// [R1] Slave drives passed-diagnostic; master samples it
// [R2] Three-bit address selects one register
// [R3] CS0- selects command block registers
// [R4] CS1- selects control registers
// [R5] DASP- open collector: activity or presence
// [R6] Host read/write strobe width per mode
// [R7] Host strobe recovery in PIO modes 3, 4
// [R8] IORDY held low at most 1250 ns
// [R9] Read data valid when IORDY released
// [R10] DMARQ change soon after read strobe; dmarq here follows dmaWant one cycle later instead
// [R11] DMARQ change soon after write strobe; dmarq here follows dmaWant one cycle later instead
// [R12] Host read strobe negated time in DMA
// [R13] Host write strobe negated time in DMA
// [R14] Host respects mode cycle time
// [R15] Device may stretch cycle via IORDY low
// [R16] Write strobe rising edge captures data
// [R17] DMARQ requests word, DMACK- answers
// [R18] Registers use low byte; data all 16
module ahp_host_port #(
  parameter int PRESENCE_CYC = 1000
) (
  input wire logic sys_clk, // Drive clock
  input wire logic reset, // Async, active high
  input wire logic [15:0] ddIn, // Host data bus level
  output logic [15:0] ddOut, // Data driven to host
  output logic ddOe, // Drive data bus
  input wire logic [2:0] da, // Host register address
  input wire logic cs0N, // Command block select
  input wire logic cs1N, // Control block select
  input wire logic diorN, // Host read strobe
  input wire logic diowN, // Host write strobe
  input wire logic dmackN, // DMA acknowledge
  output logic dmarq, // DMA request
  output logic iordyOut, // Ready pin level when driven
  output logic iordyOe, // Drives ready low
  input wire logic pdiagIn, // Passed-diagnostic pin level
  output logic pdiagOut, // Passed-diagnostic level
  output logic pdiagOe, // Pull passed-diagnostic low
  output logic daspOut, // Active/present level
  output logic daspOe, // Pull active/present low
  input wire logic slaveStrap, // Jumper: high for slave
  input wire logic diagPassed, // Core finished diagnostics ok
  input wire logic driveActive, // Core busy
  output logic peerPassed, // Slave reported pass
  output logic regWrStb, // Register write pulse
  output logic regWrCtl, // Write hits control block
  output logic [2:0] regWrAddr, // Register written
  output logic [15:0] regWrData, // Data written
  output logic regRdStb, // Register read pulse
  output logic regRdCtl, // Read hits control block
  output logic [2:0] regRdAddr, // Register read
  input wire logic [15:0] regRdData, // Read answer from core
  input wire logic regRdValid, // Read answer ready
  input wire logic dmaWant, // Core wants a DMA word moved
  input wire logic [15:0] dmaTxData, // Word for host
  output logic dmaTxTake, // Host took the word
  output logic dmaRxStb, // Word from host
  output logic [15:0] dmaRxData // Word received
);
  // Plain copy so the request deadline can bound a delay range
  localparam int DMARQ_LIM = ahp_pkg::DMARQ_MAX_CYC;
  logic [ahp_pkg::PIN_W-1:0] pinS1;
  logic [ahp_pkg::PIN_W-1:0] pinS2;
  logic [ahp_pkg::PIN_W-1:0] pinPrev;
  logic isSlave;
  logic strapDone;
  logic [1:0] strapCnt;
  logic [31:0] presCnt;
  ahp_pkg::ahp_rd_state_t rdState;
  logic [4:0] waitCnt;
  logic rdCtlHeld;
  logic [2:0] rdAddrHeld;
  logic [5:0] lowCnt;
  logic rdFall;
  logic rdRise;
  logic wrRise;
  logic acked;
  logic [1:0] wrSel;
  logic [1:0] rdSel;
  logic diorAsserted;

  // Returns {hit, control}; both selects together hit nothing
  function automatic logic [1:0] selDecode(
    input logic [ahp_pkg::PIN_W-1:0] p
  );
    logic c0;
    logic c1;
    c0 = !p[ahp_pkg::PIN_CS0];
    c1 = !p[ahp_pkg::PIN_CS1];
    if (c0 && !c1)
      selDecode = 2'h2; // see [R3]
    else if (c1 && !c0 &&
      p[ahp_pkg::PIN_DA+2 -: 2] == ahp_pkg::CTL_ADDR_HI)
      selDecode = 2'h3; // see [R4]
    else
      selDecode = 2'h0;
  endfunction

  // Low byte only, except the data register of the command block
  function automatic logic [15:0] widthMask(
    input logic ctl,
    input logic [2:0] addr,
    input logic [15:0] d
  );
    if (!ctl && addr == ahp_pkg::DATA_REG_ADDR)
      widthMask = d;
    else
      widthMask = d & ahp_pkg::BYTE_MASK; // see [R18]
  endfunction

  // Pins are asynchronous to the drive clock
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      pinS1 <= '1;
      pinS2 <= '1;
      pinPrev <= '1;
    end
    else
    begin
      pinS1 <= {slaveStrap, pdiagIn, dmackN, diowN, diorN, cs1N, cs0N,
        da, ddIn};
      pinS2 <= pinS1;
      pinPrev <= pinS2;
    end
  end

  assign rdFall = !pinS2[ahp_pkg::PIN_RD] && pinPrev[ahp_pkg::PIN_RD];
  assign rdRise = pinS2[ahp_pkg::PIN_RD] && !pinPrev[ahp_pkg::PIN_RD];
  assign wrRise = pinS2[ahp_pkg::PIN_WR] && !pinPrev[ahp_pkg::PIN_WR];
  assign acked = !pinS2[ahp_pkg::PIN_ACK];
  assign diorAsserted = !pinS2[ahp_pkg::PIN_RD];
  // Data sampled alongside the last low write-strobe sample
  assign wrSel = selDecode(pinPrev);
  assign rdSel = selDecode(pinS2);

  // Strap caught once, after reset release
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      isSlave <= 1'b0;
      strapDone <= 1'b0;
      strapCnt <= '0;
    end
    else if (!strapDone)
    begin
      // Reset fill of the synchroniser is not a strap reading
      strapCnt <= strapCnt + 2'h1;
      isSlave <= pinS2[ahp_pkg::PIN_SLAVE];
      strapDone <= strapCnt == 2'h2;
    end
  end

  // Diagnostic line: output when slave, input when master
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      pdiagOut <= 1'b0;
      pdiagOe <= 1'b0;
      peerPassed <= 1'b0;
    end
    else
    begin
      pdiagOut <= 1'b0;
      pdiagOe <= strapDone && isSlave && diagPassed; // see [R1]
      peerPassed <= strapDone && !isSlave &&
        !pinS2[ahp_pkg::PIN_DIAG]; // see [R1]
    end
  end

  // Presence first, then activity, on one open-collector line
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      presCnt <= '0;
      daspOut <= 1'b0;
      daspOe <= 1'b0;
    end
    else
    begin
      daspOut <= 1'b0;
      if (presCnt < PRESENCE_CYC)
      begin
        presCnt <= presCnt + 32'h1;
        daspOe <= strapDone && isSlave; // see [R5]
      end
      else
        daspOe <= driveActive; // see [R5]
    end
  end

  // Register writes on the write strobe's rising edge
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      regWrStb <= 1'b0;
      regWrCtl <= 1'b0;
      regWrAddr <= '0;
      regWrData <= ahp_pkg::WORD_RESET;
    end
    else
    begin
      regWrStb <= wrRise && !acked && wrSel[1]; // see [R16]
      if (wrRise && !acked && wrSel[1])
      begin
        regWrCtl <= wrSel[0];
        regWrAddr <= pinPrev[ahp_pkg::PIN_DA +: 3]; // see [R2]
        regWrData <= widthMask(wrSel[0], pinPrev[ahp_pkg::PIN_DA +: 3],
          pinPrev[ahp_pkg::PIN_DD +: 16]); // see [R16]
      end
    end
  end

  // Register reads stretched by wait states until the core answers or the wait limit runs out
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      rdState <= ahp_pkg::RD_IDLE;
      waitCnt <= '0;
      rdCtlHeld <= 1'b0;
      rdAddrHeld <= '0;
      regRdStb <= 1'b0;
      regRdCtl <= 1'b0;
      regRdAddr <= '0;
      iordyOut <= 1'b0;
      iordyOe <= 1'b0;
    end
    else
    begin
      regRdStb <= 1'b0;
      iordyOut <= 1'b0;
      case (rdState)
        ahp_pkg::RD_IDLE:
        begin
          if (rdFall && !acked && rdSel[1])
          begin
            regRdStb <= 1'b1;
            regRdCtl <= rdSel[0];
            regRdAddr <= pinS2[ahp_pkg::PIN_DA +: 3]; // see [R2]
            rdCtlHeld <= rdSel[0];
            rdAddrHeld <= pinS2[ahp_pkg::PIN_DA +: 3];
            iordyOe <= 1'b1; // see [R15]
            waitCnt <= '0;
            rdState <= ahp_pkg::RD_WAIT;
          end
        end
        ahp_pkg::RD_WAIT:
        begin
          waitCnt <= waitCnt + 5'h1;
          // Give up waiting rather than hang the host
          if (regRdValid ||
            waitCnt == 5'(ahp_pkg::IORDY_MAX_CYC - 1)) // see [R8]
          begin
            iordyOe <= 1'b0;
            rdState <= ahp_pkg::RD_HOLD;
          end
        end
        ahp_pkg::RD_HOLD:
        begin
          if (!diorAsserted)
            rdState <= ahp_pkg::RD_IDLE;
        end
        default:
        begin
          iordyOe <= 1'b0;
          rdState <= ahp_pkg::RD_IDLE;
        end
      endcase
    end
  end

  // Data bus drive for register reads and DMA reads
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      ddOut <= ahp_pkg::WORD_RESET;
      ddOe <= 1'b0;
    end
    else
    begin
      ddOe <= diorAsserted && (acked || rdState != ahp_pkg::RD_IDLE ||
        (rdFall && rdSel[1]));
      if (rdState == ahp_pkg::RD_WAIT && (regRdValid ||
        waitCnt == 5'(ahp_pkg::IORDY_MAX_CYC - 1)))
        ddOut <= widthMask(rdCtlHeld, rdAddrHeld, regRdData); // see [R9]
      else if (acked && rdFall)
        ddOut <= dmaTxData; // see [R18]
    end
  end

  // Multiword DMA: request follows the core, words move per strobe
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      dmarq <= 1'b0;
      dmaTxTake <= 1'b0;
      dmaRxStb <= 1'b0;
      dmaRxData <= ahp_pkg::WORD_RESET;
    end
    else
    begin
      // Request follows the core one cycle later, not tied to any strobe edge
      dmarq <= dmaWant; // see [R17] [R10] [R11]
      dmaTxTake <= acked && rdRise; // see [R17]
      dmaRxStb <= acked && wrRise; // see [R17]
      if (acked && wrRise)
        dmaRxData <= pinPrev[ahp_pkg::PIN_DD +: 16]; // see [R18]
    end
  end

  // Helper: cycles the ready line has been held low
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      lowCnt <= '0;
    else if (iordyOe)
      lowCnt <= lowCnt + 6'h1;
    else
      lowCnt <= '0;
  end

  property p_iordyLimit;
    @(posedge sys_clk) disable iff (reset)
      lowCnt <= 6'(ahp_pkg::IORDY_MAX_CYC);
  endproperty
  a_iordyLimit: assert property (p_iordyLimit) // see [R8]
    else $error("ready held low too long");

  property p_dataAtRelease;
    @(posedge sys_clk) disable iff (reset)
      $fell(iordyOe) |-> ddOut == widthMask(rdCtlHeld, rdAddrHeld,
        $past(regRdData));
  endproperty
  a_dataAtRelease: assert property (p_dataAtRelease) // see [R9]
    else $error("read data not valid at ready release");

  property p_waitOnRead;
    @(posedge sys_clk) disable iff (reset)
      regRdStb |-> iordyOe;
  endproperty
  a_waitOnRead: assert property (p_waitOnRead) // see [R15]
    else $error("read taken without wait state");

  property p_writeCapture;
    @(posedge sys_clk) disable iff (reset)
      (wrRise && !acked && wrSel == 2'h2 &&
        pinPrev[ahp_pkg::PIN_DA +: 3] == ahp_pkg::DATA_REG_ADDR)
      |=> regWrStb && !regWrCtl && regWrData == $past(pinPrev[15:0]);
  endproperty
  a_writeCapture: assert property (p_writeCapture) // see [R16] [R3]
    else $error("data register write not captured");

  property p_byteRegs;
    @(posedge sys_clk) disable iff (reset)
      regWrStb && (regWrCtl || regWrAddr != ahp_pkg::DATA_REG_ADDR)
      |-> regWrData[15:8] == 8'h00;
  endproperty
  a_byteRegs: assert property (p_byteRegs) // see [R18]
    else $error("register write wider than a byte");

  property p_ctlDecode;
    @(posedge sys_clk) disable iff (reset)
      regWrStb && regWrCtl |-> regWrAddr[2:1] == ahp_pkg::CTL_ADDR_HI;
  endproperty
  a_ctlDecode: assert property (p_ctlDecode) // see [R4] [R2]
    else $error("control write outside control block");

  property p_dmarqFollow;
    @(posedge sys_clk) disable iff (reset)
      $fell(dmaWant) |-> ##[0:DMARQ_LIM] !dmarq;
  endproperty
  a_dmarqFollow: assert property (p_dmarqFollow) // see [R10] [R11]
    else $error("request not dropped in time");

  property p_dmaNoRegs;
    @(posedge sys_clk) disable iff (reset)
      acked && (wrRise || rdFall) |=> !regWrStb && !regRdStb;
  endproperty
  a_dmaNoRegs: assert property (p_dmaNoRegs) // see [R17]
    else $error("DMA strobe reached registers");

  property p_diagDir;
    @(posedge sys_clk) disable iff (reset)
      pdiagOe |-> isSlave && !peerPassed;
  endproperty
  a_diagDir: assert property (p_diagDir) // see [R1]
    else $error("diagnostic line driven as master");

  property p_daspSource;
    @(posedge sys_clk) disable iff (reset)
      presCnt >= PRESENCE_CYC && $past(presCnt) >= PRESENCE_CYC
      |-> daspOe == $past(driveActive);
  endproperty
  a_daspSource: assert property (p_daspSource) // see [R5]
    else $error("activity not shown on shared line");
endmodule

// file: tb/ahp_host_model.sv
`timescale 1ns/1ps
module ahp_host_model (
  input wire logic sys_clk, // Drive clock
  input wire logic [15:0] ddBus, // Resolved data bus
  input wire logic iordy, // Resolved ready pin
  input wire logic dmarq, // DMA request
  output logic [15:0] hostDd, // Host data, inverted once released
  output logic [2:0] da, // Register address
  output logic cs0N, // Command select
  output logic cs1N, // Control select
  output logic diorN, // Read strobe
  output logic diowN, // Write strobe
  output logic dmackN, // DMA acknowledge
  output logic hung // A bounded wait ran out
);
  initial
  begin
    {hostDd, da, hung} = '0;
    {cs0N, cs1N, diorN, diowN, dmackN} = 5'h1f;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Mode 0 figures throughout: 6 cycles meets every width and gap
  task automatic xfer(input logic dm, rd, ctl, input logic [2:0] a,
    input logic [15:0] d, output logic [15:0] q);
    int i;
    for (i = 0; dm && dmarq !== 1'b1 && i < 40; i++) cyc(1);
    hung <= hung | (i == 40);
    da <= a;
    cs0N <= dm | ctl;
    cs1N <= dm | ~ctl;
    dmackN <= ~dm;
    hostDd <= rd ? ~d : d;
    cyc(2);
    if (rd)
      diorN <= 1'b0;
    else
      diowN <= 1'b0;
    cyc(6);
    for (i = 0; rd && iordy !== 1'b1 && i < 40; i++) cyc(1);
    hung <= hung | (i == 40);
    q = ddBus;
    diorN <= 1'b1;
    diowN <= 1'b1;
    cyc(1);
    {cs0N, cs1N, dmackN} <= 3'h7;
    hostDd <= ~hostDd;
    cyc(6);
  endtask
endmodule

// file: tb/ahp_host_port_test.sv
`timescale 1ns/1ps
module ahp_host_port_test;
  localparam int PRES = 20;
  logic sys_clk = 0, reset = 1, slaveStrap = 0, diagPassed = 0;
  logic driveActive = 0, regRdValid = 0, dmaWant = 0, peerPull = 0;
  logic ans = 1, ddOe, dmarq, iordyOut, iordyOe, pdiagOut, pdiagOe;
  logic daspOut, daspOe, peerPassed, regWrStb, regWrCtl, regRdStb;
  logic regRdCtl, dmaTxTake, dmaRxStb, hung, cs0N, cs1N;
  logic diorN, diowN, dmackN;
  logic [2:0] da, regWrAddr, regRdAddr;
  logic [15:0] hostDd, ddOut, regWrData, dmaRxData, q;
  logic [15:0] dmaTxData = 16'h0000, regRdData;
  int err_total = 0, total_checks = 0, nWr = 0, nTake = 0, nRx = 0;
  int hold = 0, lowRun = 0, lowMax = 0, ticks = 0;
  wire logic [15:0] ddIn = ddOe ? ddOut : hostDd;
  wire logic iordy = ~iordyOe; // Pulled up when released
  wire logic pdiagIn = ~(pdiagOe | peerPull);
  assign regRdData = 16'hc3a0 | regRdAddr;
  always #20 sys_clk = ~sys_clk;
  ahp_host_port #(.PRESENCE_CYC(PRES)) u_ahp_host_port (.sys_clk,
    .reset, .ddIn, .ddOut, .ddOe, .da, .cs0N, .cs1N, .diorN, .diowN,
    .dmackN, .dmarq, .iordyOut, .iordyOe, .pdiagIn, .pdiagOut, .pdiagOe,
    .daspOut, .daspOe, .slaveStrap, .diagPassed, .driveActive,
    .peerPassed, .regWrStb, .regWrCtl, .regWrAddr, .regWrData, .regRdStb,
    .regRdCtl, .regRdAddr, .regRdData, .regRdValid, .dmaWant, .dmaTxData,
    .dmaTxTake, .dmaRxStb, .dmaRxData);
  ahp_host_model u_ahp_host_model (.sys_clk, .ddBus(ddIn), .iordy,
    .dmarq, .hostDd, .da, .cs0N, .cs1N, .diorN, .diowN, .dmackN, .hung);
  // Core side answers reads slowly so the wait state really stretches
  always @(posedge sys_clk)
  begin
    hold <= (regRdStb === 1'b1) ? 8 : (hold > 0 ? hold - 1 : 0);
    // One-cycle answer, so a stale answer never ends the next read
    regRdValid <= ans && hold == 1;
    nWr <= nWr + (regWrStb === 1'b1);
    nTake <= nTake + (dmaTxTake === 1'b1);
    nRx <= nRx + (dmaRxStb === 1'b1);
    lowRun <= (iordyOe === 1'b1) ? lowRun + 1 : 0;
    lowMax <= lowRun > lowMax ? lowRun : lowMax;
    ticks <= ticks + 1;
    if (hung === 1'b1 || ticks > 20000)
    begin
      err_total++;
      end_of_test;
    end
  end
  task automatic chk(input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic do_reset(input logic strap);
    reset <= 1'b1;
    slaveStrap <= strap;
    wt(2);
    reset <= 1'b0;
    wt(2);
  endtask
  task automatic go(input logic dm, rd, ctl, input logic [2:0] a,
    input logic [15:0] d);
    u_ahp_host_model.xfer(dm, rd, ctl, a, d, q);
  endtask
  task automatic t_write;
    int n;
    n = nWr;
    go(0, 0, 0, 3'h3, 16'h5aa5);
    chk({regWrCtl, regWrAddr, regWrData}, 20'h300a5);
    go(0, 0, 0, 3'h0, 16'hbeef);
    chk({regWrCtl, regWrAddr, regWrData}, 20'h0beef);
    go(0, 0, 1, 3'h6, 16'h1234);
    chk({regWrCtl, regWrAddr, regWrData}, 20'he0034);
    go(0, 0, 1, 3'h2, 16'h4321);
    chk(nWr - n, 3);
  endtask
  task automatic t_read;
    go(0, 1, 0, 3'h7, 16'h0000);
    chk(q, 16'h00a7);
    chk({regRdCtl, regRdAddr}, 4'h7);
    chk(lowMax >= 5, 1);
    go(0, 1, 0, 3'h0, 16'h0000);
    chk(q, 16'hc3a0);
    ans <= 1'b0;
    go(0, 1, 1, 3'h7, 16'h0000);
    chk({regRdCtl, regRdAddr}, 4'hf);
    chk(q, 16'h00a7);
    chk(lowMax, ahp_pkg::IORDY_MAX_CYC);
    chk({iordyOut, ddOe}, 2'h0);
    ans <= 1'b1;
  endtask
  task automatic t_dma;
    dmaWant <= 1'b1;
    dmaTxData <= 16'h8421;
    wt(2);
    chk(dmarq, 1);
    go(1, 0, 0, 3'h0, 16'hf00d);
    chk({nRx[3:0], dmaRxData}, 20'h1f00d);
    go(1, 1, 0, 3'h0, 16'h0000);
    chk({nTake[3:0], q}, 20'h18421);
    dmaWant <= 1'b0;
    wt(2);
    chk(dmarq, 0);
  endtask
  task automatic t_diag;
    peerPull <= 1'b1;
    wt(4);
    chk({peerPassed, pdiagOe, pdiagOut}, 3'h4);
    peerPull <= 1'b0;
    diagPassed <= 1'b1;
    do_reset(1'b1);
    // Strap settles three edges after release, outputs one later
    wt(4);
    chk({pdiagOe, daspOe, peerPassed}, 3'h6);
    wt(PRES + 2);
    chk(daspOe, 0);
    driveActive <= 1'b1;
    wt(3);
    chk({daspOe, daspOut}, 2'h2);
  endtask
  initial
  begin
    do_reset(1'b0);
    t_write;
    t_read;
    t_dma;
    t_diag;
    end_of_test;
  end
endmodule
